//--- hdl/uls_pkg.sv
package uls_pkg;
    // register byte offsets
    localparam logic [7:0] LS_ADDR   = 8'h00;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] IST_ADDR  = 8'h08;
    localparam logic [7:0] IMSK_ADDR = 8'h0c;
    // line status bit positions
    localparam int unsigned LS_FIFO_ERR = 7;
    localparam int unsigned LS_TEMT     = 6;
    localparam int unsigned LS_THRE     = 5;
    localparam int unsigned LS_BRK      = 4;
    localparam int unsigned LS_FE       = 3;
    localparam int unsigned LS_PE       = 2;
    localparam int unsigned LS_OE       = 1;
    localparam int unsigned LS_DR       = 0;
    // control bit positions
    localparam int unsigned CTRL_FIFO_EN = 0;
    localparam int unsigned CTRL_W       = 1;
    // interrupt status and mask bit positions
    localparam int unsigned IRQ_THRE  = 0;
    localparam int unsigned IRQ_RXERR = 1;
    localparam int unsigned IRQ_BRK   = 2;
    localparam int unsigned IRQ_OVR   = 3;
    localparam int unsigned IRQ_DR    = 4;
    localparam int unsigned IRQ_W     = 5;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;
    localparam logic [IRQ_W-1:0]  IRQ_RST  = 5'h00;
    localparam logic [7:0]        LS_RST   = 8'h60;
    // default sizes and counts
    localparam int RXQ_DEPTH  = 16;
    localparam int FRAME_BITS = 10;
    // ahb transfer type with a request in it
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
    } uls_err_t;

    typedef enum logic [1:0] {
        BRK_IDLE  = 2'b00,
        BRK_COUNT = 2'b01,
        BRK_HELD  = 2'b10
    } uls_brk_st_t;
endpackage

//--- hdl/uls_rxq_if.sv
`timescale 1ns/1ps
interface uls_rxq_if;
    logic             push;
    logic             pop;
    logic             flush;
    logic             one_deep;
    uls_pkg::uls_err_t push_err;
    uls_pkg::uls_err_t head_err;
    logic             any_err;
    logic             not_empty;
    logic             full;
    modport store (input push, pop, flush, one_deep, push_err,
                   output head_err, any_err, not_empty, full);
    modport user  (output push, pop, flush, one_deep, push_err,
                   input head_err, any_err, not_empty, full);
endinterface

//--- hdl/uls_err_fifo.sv
`timescale 1ns/1ps
module uls_err_fifo #(
    parameter int DEPTH = uls_pkg::RXQ_DEPTH
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic ce_in,
    // queue port
    uls_rxq_if.store q
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    uls_pkg::uls_err_t mem_q [DEPTH];
    logic [PW-1:0]     wr_q;
    logic [PW-1:0]     rd_q;
    logic [CW-1:0]     cnt_q;
    logic [CW-1:0]     errs_q;
    logic [CW-1:0]     cap;
    logic              do_push;
    logic              do_pop;

    // non-fifo mode behaves as a single holding stage
    assign cap     = q.one_deep ? CW'(1) : CW'(DEPTH);
    assign do_pop  = q.pop & (cnt_q != '0);
    // a full queue refuses the push; the top flags the overrun
    assign do_push = q.push & (cnt_q < cap);

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_ent
            always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    mem_q[i] <= '0;
                end else if (ce_in && do_push && wr_q == PW'(i)) begin
                    mem_q[i] <= q.push_err;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            if (q.flush) begin
                wr_q  <= '0;
                rd_q  <= '0;
                cnt_q <= '0;
            end else begin
                if (do_push) begin
                    wr_q <= wr_q + PW'(1);
                end
                if (do_pop) begin
                    rd_q <= rd_q + PW'(1);
                end
                cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
            end
        end
    end

    // count of held entries carrying any error flag
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            errs_q <= '0;
        end else if (ce_in) begin
            if (q.flush) begin
                errs_q <= '0;
            end else begin
                errs_q <= errs_q + CW'(do_push & (|q.push_err))
                                 - CW'(do_pop & (|mem_q[rd_q]));
            end
        end
    end

    assign q.head_err  = (cnt_q != '0) ? mem_q[rd_q] : '0;
    assign q.any_err   = (errs_q != '0);
    assign q.not_empty = (cnt_q != '0);
    assign q.full      = (cnt_q >= cap);
endmodule // uls_err_fifo

//--- hdl/uls_line_status.sv
//
// Overview of operation
// - error summary set when queued char errs
// - summary clears when no erroneous char remains
// - non-fifo: temt when holding and shift empty
// - temt low while either stage holds data
// - fifo mode: temt when fifo, shift empty
// - non-fifo: thre set on holding-to-shift move
// - thre cleared as host writes holding stage
// - enabled thre raises interrupt request
// - fifo mode: thre tracks transmit fifo empty
// - break flag after full frame low
// - one break char per break condition
// - framing error on missing stop bit
// - fifo mode: flags follow head character
// - error flags read zero after reset
// - parity error flag follows head character
// - overrun when char completes into full queue
// - data ready while any char is held
//
`timescale 1ns/1ps
module uls_line_status #(
    parameter int RXQ_DEPTH  = uls_pkg::RXQ_DEPTH,
    parameter int FRAME_BITS = uls_pkg::FRAME_BITS
) (
    // clock, reset, enable
    input  wire logic        sys_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        ce_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // receive side
    input  wire logic        rx_pin_in,
    input  wire logic        baud_tick_in,
    input  wire logic        rx_char_done_in,
    input  wire logic        rx_parity_err_in,
    input  wire logic        rx_stop_bit_in,
    input  wire logic        rx_pop_in,
    // transmit side
    input  wire logic        tx_wr_in,
    input  wire logic        tx_load_in,
    input  wire logic        tx_shift_busy_in,
    input  wire logic        tx_fifo_empty_in,
    // status
    output logic      [7:0]  line_status_out,
    output logic             fifo_mode_out,
    output logic             irq_out
);
    localparam int BCW = $clog2(FRAME_BITS + 1);

    uls_rxq_if rxq ();

    uls_err_fifo #(
        .DEPTH (RXQ_DEPTH)
    ) u_rxq (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .ce_in      (ce_in),
        .q          (rxq.store)
    );

    // bus state
    logic                             wr_pend_q;
    logic [7:0]                       wr_addr_q;
    logic [31:0]                      hrdata_q;
    logic                             hreadyout_q;
    logic                             hresp_q;
    logic                             addr_ok;
    logic                             ls_read;
    logic [31:0]                      rd_mux;
    // registers
    logic [uls_pkg::CTRL_W-1:0]       ctrl_q;
    logic [uls_pkg::IRQ_W-1:0]        ist_q;
    logic [uls_pkg::IRQ_W-1:0]        imsk_q;
    logic [uls_pkg::IRQ_W-1:0]        ist_set;
    logic [uls_pkg::IRQ_W-1:0]        ist_clr;
    logic                             irq_q;
    logic                             fifo_en;
    // rx pin synchroniser
    logic                             rx_s1_q;
    logic                             rx_s2_q;
    logic                             rx_s3_q;
    logic                             rx_lvl_q;
    // break detector
    uls_pkg::uls_brk_st_t             brk_st_q;
    logic [BCW-1:0]                   brk_cnt_q;
    logic                             brk_push;
    // status flags
    logic                             thre_q;
    logic                             ovr_q;
    logic                             hold_empty;
    logic [7:0]                       ls_d;
    logic [7:0]                       ls_q;

    assign fifo_en = ctrl_q[uls_pkg::CTRL_FIFO_EN];

    // ahb-lite slave
    assign addr_ok = hsel_in & htrans_in[uls_pkg::HTRANS_ACTIVE_BIT] & hready_in;
    assign ls_read = addr_ok & ~hwrite_in & (haddr_in == uls_pkg::LS_ADDR);

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr_in)
            uls_pkg::LS_ADDR:   rd_mux = {24'h00_0000, ls_q};
            uls_pkg::CTRL_ADDR: rd_mux = {31'h0000_0000, ctrl_q};
            uls_pkg::IST_ADDR:  rd_mux = {27'h000_0000, ist_q};
            uls_pkg::IMSK_ADDR: rd_mux = {27'h000_0000, imsk_q};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // zero wait state: read data is registered during the address phase
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else if (ce_in) begin
            wr_pend_q   <= addr_ok & hwrite_in;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            if (addr_ok && hwrite_in) begin
                wr_addr_q <= haddr_in;
            end
            if (addr_ok && !hwrite_in) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // control register; a mode change flushes the receive queue
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_q <= uls_pkg::CTRL_RST;
        end else if (ce_in && wr_pend_q && wr_addr_q == uls_pkg::CTRL_ADDR) begin
            ctrl_q <= hwdata_in[uls_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            imsk_q <= uls_pkg::IRQ_RST;
        end else if (ce_in && wr_pend_q && wr_addr_q == uls_pkg::IMSK_ADDR) begin
            imsk_q <= hwdata_in[uls_pkg::IRQ_W-1:0];
        end
    end

    // rx pin synchroniser
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
        end else if (ce_in) begin
            rx_s1_q <= rx_pin_in;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
        end
    end

    // level only moves when the last two stages agree
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rx_lvl_q <= 1'b1;
        end else if (ce_in && rx_s2_q == rx_s3_q) begin
            rx_lvl_q <= rx_s3_q;
        end
    end

    // break detector
    // frame-long low
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            brk_st_q  <= uls_pkg::BRK_IDLE;
            brk_cnt_q <= '0;
        end else if (ce_in) begin
            unique case (brk_st_q)
                uls_pkg::BRK_IDLE: begin
                    brk_cnt_q <= '0;
                    if (!rx_lvl_q) begin
                        brk_st_q <= uls_pkg::BRK_COUNT;
                    end
                end
                uls_pkg::BRK_COUNT: begin
                    if (rx_lvl_q) begin
                        brk_st_q <= uls_pkg::BRK_IDLE;
                    end else if (brk_push) begin
                        brk_st_q <= uls_pkg::BRK_HELD;
                    end else if (baud_tick_in) begin
                        brk_cnt_q <= brk_cnt_q + BCW'(1);
                    end
                end
                uls_pkg::BRK_HELD: begin
                    // stays here however long the line is held low
                    if (rx_lvl_q) begin
                        brk_st_q <= uls_pkg::BRK_IDLE;
                    end
                end
                default: begin
                    brk_st_q <= uls_pkg::BRK_IDLE;
                end
            endcase
        end
    end

    assign brk_push = (brk_st_q == uls_pkg::BRK_COUNT) && !rx_lvl_q
                      && (brk_cnt_q == BCW'(FRAME_BITS));

    // receive queue
    // stop bit check
    always_comb begin
        rxq.push_err = '0;
        if (brk_push) begin
            rxq.push_err.brk = 1'b1;
            rxq.push_err.fe  = 1'b1;
        end else begin
            rxq.push_err.fe = ~rx_stop_bit_in;
            rxq.push_err.pe = rx_parity_err_in;
        end
    end

    // a break takes the push slot; the receiver is expected to drop its own char
    assign rxq.push     = brk_push | rx_char_done_in;
    assign rxq.pop      = rx_pop_in;
    assign rxq.one_deep = ~fifo_en;
    assign rxq.flush    = wr_pend_q && (wr_addr_q == uls_pkg::CTRL_ADDR)
                          && (hwdata_in[uls_pkg::CTRL_FIFO_EN] != fifo_en);

    // overrun capture
    // cleared by reading line status; a new overrun in that cycle wins
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ovr_q <= 1'b0;
        end else if (ce_in) begin
            if (rxq.push && rxq.full) begin
                ovr_q <= 1'b1;
            end else if (ls_read) begin
                ovr_q <= 1'b0;
            end
        end
    end

    // transmit holding flag
    // set on load
    // cleared by write
    // a write in the same cycle as a load leaves the stage full
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            thre_q <= 1'b1;
        end else if (ce_in) begin
            if (tx_wr_in) begin
                thre_q <= 1'b0;
            end else if (tx_load_in) begin
                thre_q <= 1'b1;
            end
        end
    end

    assign hold_empty = fifo_en ? (tx_fifo_empty_in & ~tx_wr_in) : thre_q;

    // line status assembly
    // software never writes it
    always_comb begin
        ls_d = 8'h00;
        ls_d[uls_pkg::LS_FIFO_ERR] = rxq.any_err;
        ls_d[uls_pkg::LS_TEMT] = hold_empty & ~tx_shift_busy_in;
        ls_d[uls_pkg::LS_THRE] = hold_empty;
        ls_d[uls_pkg::LS_BRK] = rxq.head_err.brk;
        ls_d[uls_pkg::LS_FE]  = rxq.head_err.fe;
        ls_d[uls_pkg::LS_PE]  = rxq.head_err.pe;
        ls_d[uls_pkg::LS_OE]  = ovr_q;
        ls_d[uls_pkg::LS_DR] = rxq.not_empty;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ls_q <= uls_pkg::LS_RST;
        end else if (ce_in) begin
            ls_q <= ls_d;
        end
    end

    // interrupts
    // thre keeps its bit set while the flag stands
    always_comb begin
        ist_set                     = '0;
        ist_set[uls_pkg::IRQ_THRE]  = ls_q[uls_pkg::LS_THRE];
        ist_set[uls_pkg::IRQ_RXERR] = rxq.push & (|rxq.push_err) & ~rxq.full;
        ist_set[uls_pkg::IRQ_BRK]   = brk_push;
        ist_set[uls_pkg::IRQ_OVR]   = rxq.push & rxq.full;
        ist_set[uls_pkg::IRQ_DR]    = rxq.push & ~rxq.full;
    end

    assign ist_clr = (wr_pend_q && wr_addr_q == uls_pkg::IST_ADDR)
                     ? hwdata_in[uls_pkg::IRQ_W-1:0] : '0;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ist_q <= uls_pkg::IRQ_RST;
        end else if (ce_in) begin
            ist_q <= (ist_q & ~ist_clr) | ist_set;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_q <= 1'b0;
        end else if (ce_in) begin
            irq_q <= |(ist_q & imsk_q);
        end
    end

    // outputs
    assign hrdata_out      = hrdata_q;
    assign hreadyout_out   = hreadyout_q;
    assign hresp_out       = hresp_q;
    assign line_status_out = ls_q;
    assign fifo_mode_out   = fifo_en;
    assign irq_out         = irq_q;
endmodule // uls_line_status

//--- bench/uls_line_status_assertions.sv
`timescale 1ns/1ps
module uls_line_status_assertions #(
    parameter int RXQ_DEPTH  = 16,
    parameter int FRAME_BITS = 10
) (
    // clock and reset
    input wire logic       sys_clk_in,
    input wire logic       arst_n_in,
    // receive and transmit events
    input wire logic       rx_char_done_in,
    input wire logic       rx_parity_err_in,
    input wire logic       rx_stop_bit_in,
    input wire logic       rx_pop_in,
    input wire logic       tx_wr_in,
    input wire logic       tx_load_in,
    input wire logic       tx_shift_busy_in,
    input wire logic       tx_fifo_empty_in,
    // status
    input wire logic [7:0] line_status_out,
    input wire logic       fifo_mode_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // char lands in an empty queue, so it becomes the head
    sequence lone_push;
        rx_char_done_in && !rx_pop_in && !line_status_out[0] && !$past(rx_char_done_in);
    endsequence
    // host write not followed at once by a move to the shift stage
    sequence host_load;
        tx_wr_in && !fifo_mode_out ##1 !tx_load_in;
    endsequence

    fe_head_a: assert property (
        lone_push |-> ##2 (line_status_out[3] == !$past(rx_stop_bit_in, 2)))
        else $error("framing flag does not follow head char");
    pe_head_a: assert property (
        lone_push |-> ##2 (line_status_out[2] == $past(rx_parity_err_in, 2)))
        else $error("parity flag does not follow head char");
    data_ready_a: assert property (
        rx_char_done_in |-> ##2 line_status_out[0])
        else $error("data ready missing after char");
    err_sum_a: assert property (
        (|line_status_out[4:2]) |-> line_status_out[7])
        else $error("error summary clear while head has error");
    temt_busy_a: assert property (
        $past(arst_n_in, 2) && $past(tx_shift_busy_in) |-> !line_status_out[6])
        else $error("transmitter empty while shift stage busy");
    temt_thre_a: assert property (
        $past(arst_n_in, 2) |-> line_status_out[6] == (line_status_out[5] && !$past(tx_shift_busy_in)))
        else $error("transmitter empty disagrees with holding and shift stages");
    thre_wr_a: assert property (
        host_load |-> ##1 !line_status_out[5])
        else $error("holding empty stays set after host write");
    thre_load_a: assert property (
        tx_load_in && !tx_wr_in && !fifo_mode_out |-> ##2 line_status_out[5])
        else $error("holding empty not set after move to shift");
    fifo_thre_a: assert property (
        fifo_mode_out |=> line_status_out[5] == ($past(tx_fifo_empty_in) && !$past(tx_wr_in)))
        else $error("holding empty does not track transmit fifo");
endmodule // uls_line_status_assertions

bind uls_line_status uls_line_status_assertions #(
    .RXQ_DEPTH (RXQ_DEPTH),
    .FRAME_BITS(FRAME_BITS)
) chk (
    .sys_clk_in, .arst_n_in, .rx_char_done_in, .rx_parity_err_in, .rx_stop_bit_in, .rx_pop_in,
    .tx_wr_in, .tx_load_in, .tx_shift_busy_in, .tx_fifo_empty_in, .line_status_out, .fifo_mode_out
);

//--- bench/uls_host.sv
`timescale 1ns/1ps
module uls_host (
    // clock and answer
    input  wire logic        sys_clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    // request
    output logic             hsel_out,
    output logic      [7:0]  haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [2:0]  hsize_out,
    output logic      [31:0] hwdata_out
);
    logic stuck = 1'b0;

    initial begin
        hsel_out   = 1'b0;
        haddr_out  = 8'h00;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h00000000;
    end

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (hready_in !== 1'b1 && n < 32);
        if (hready_in !== 1'b1) stuck = 1'b1;
    endtask

    // single word transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel_out   <= 1'b1;
        haddr_out  <= a;
        htrans_out <= 2'h2;
        hwrite_out <= w;
        wait_ready();
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        wait_ready();
        q = hrdata_in;
        // released data must not look like a held word
        hwdata_out <= ~d;
    endtask
endmodule // uls_host

//--- bench/tb_uls_line_status.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("wrong value at %0t: got %h want %h", $time, g, e); \
        end \
    end
module tb_uls_line_status;
    localparam int DEPTH  = 4;
    localparam int FRAMES = 3;
    logic        sys_clk_in = 1'b0;
    logic        arst_n_in  = 1'b0;
    logic        hsel_in, hwrite_in, hready, hresp, irq, fmode;
    logic [7:0]  haddr_in, ls;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [31:0] hwdata_in, hrdata, got, want;
    logic        rx_pin = 1'b1, rx_pe = 1'b0, rx_stop = 1'b1, busy = 1'b0, fempty = 1'b1;
    logic [4:0]  pv = 5'h00;
    logic [15:0] lfsr_q = 16'h615f;
    logic [31:0] exp_q[$];
    event        got_ev;
    int          errors = 0;
    int          n_checks = 0;

    always #25 sys_clk_in = ~sys_clk_in;

    uls_host host (.sys_clk_in, .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel_in), .haddr_out(haddr_in),
        .htrans_out(htrans_in), .hwrite_out(hwrite_in), .hsize_out(hsize_in), .hwdata_out(hwdata_in));

    uls_line_status #(.RXQ_DEPTH(DEPTH), .FRAME_BITS(FRAMES)) DUT (
        .sys_clk_in, .arst_n_in, .ce_in(1'b1), .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in,
        .hwdata_in, .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .rx_pin_in(rx_pin), .baud_tick_in(pv[4]), .rx_char_done_in(pv[0]), .rx_parity_err_in(rx_pe),
        .rx_stop_bit_in(rx_stop), .rx_pop_in(pv[1]), .tx_wr_in(pv[2]), .tx_load_in(pv[3]),
        .tx_shift_busy_in(busy), .tx_fifo_empty_in(fempty), .line_status_out(ls), .fifo_mode_out(fmode),
        .irq_out(irq));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // results are compared in arrival order against the noted expectations
    always @(got_ev) begin
        want = exp_q.pop_front();
        `CHK(got, want)
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 32'h00000000, got);
        ->got_ev;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, q);
    endtask

    // one-cycle event pulses, then room for the two-edge status lag
    task automatic pulse(input logic [4:0] m);
        pv <= m;
        @(posedge sys_clk_in);
        pv <= 5'h00;
        repeat (3) @(posedge sys_clk_in);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        rd(uls_pkg::LS_ADDR, 32'h00000060);
        rd(uls_pkg::CTRL_ADDR, 32'h00000000);
        rd(8'h10, 32'h00000000);
        wr(uls_pkg::LS_ADDR, 32'h000000ff);
        rd(uls_pkg::LS_ADDR, 32'h00000060);
        pulse(5'h04);
        rd(uls_pkg::LS_ADDR, 32'h00000000);
        busy <= 1'b1;
        pulse(5'h08);
        rd(uls_pkg::LS_ADDR, 32'h00000020);
        busy <= 1'b0;
        pulse(5'h00);
        rd(uls_pkg::LS_ADDR, 32'h00000060);
        // interrupt: raise, clear, mask
        wr(uls_pkg::IMSK_ADDR, 32'h00000001);
        rd(uls_pkg::IST_ADDR, 32'h00000001);
        `CHK(irq, 1'b1)
        pulse(5'h04);
        wr(uls_pkg::IST_ADDR, 32'h00000001);
        rd(uls_pkg::IST_ADDR, 32'h00000000);
        `CHK(irq, 1'b0)
        pulse(5'h08);
        rd(uls_pkg::IST_ADDR, 32'h00000001);
        `CHK(irq, 1'b1)
        wr(uls_pkg::IMSK_ADDR, 32'h00000000);
        repeat (2) @(posedge sys_clk_in);
        `CHK(irq, 1'b0)
        // random error flags, one-deep holding stage
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            rx_pe <= lfsr_q[0];
            rx_stop <= lfsr_q[1];
            pulse(5'h01);
            rd(uls_pkg::LS_ADDR, {24'h000000, lfsr_q[0] | !lfsr_q[1], 2'b11, 1'b0, !lfsr_q[1], lfsr_q[0], 2'b01});
            pulse(5'h02);
            rd(uls_pkg::LS_ADDR, 32'h00000060);
        end
        rx_pe <= 1'b0;
        rx_stop <= 1'b1;
        pulse(5'h01);
        pulse(5'h01);
        rd(uls_pkg::LS_ADDR, 32'h00000063);
        rd(uls_pkg::LS_ADDR, 32'h00000061);
        pulse(5'h02);
        // fifo mode: head char decides the flags
        wr(uls_pkg::CTRL_ADDR, 32'h00000001);
        rd(uls_pkg::CTRL_ADDR, 32'h00000001);
        `CHK(fmode, 1'b1)
        rx_stop <= 1'b0;
        pulse(5'h01);
        rx_stop <= 1'b1;
        pulse(5'h01);
        rd(uls_pkg::LS_ADDR, 32'h000000e9);
        pulse(5'h02);
        rd(uls_pkg::LS_ADDR, 32'h00000061);
        rx_pe <= 1'b1;
        pulse(5'h01);
        rx_pe <= 1'b0;
        rd(uls_pkg::LS_ADDR, 32'h000000e1);
        pulse(5'h02);
        rd(uls_pkg::LS_ADDR, 32'h000000e5);
        pulse(5'h02);
        rd(uls_pkg::LS_ADDR, 32'h00000060);
        fempty <= 1'b0;
        pulse(5'h00);
        rd(uls_pkg::LS_ADDR, 32'h00000000);
        busy <= 1'b1;
        fempty <= 1'b1;
        pulse(5'h04);
        rd(uls_pkg::LS_ADDR, 32'h00000020);
        busy <= 1'b0;
        // long break yields a single break char
        rx_pin <= 1'b0;
        repeat (4 * FRAMES) pulse(5'h10);
        rd(uls_pkg::LS_ADDR, 32'h000000f9);
        pulse(5'h02);
        rd(uls_pkg::LS_ADDR, 32'h00000060);
        rx_pin <= 1'b1;
        `CHK(host.stuck, 1'b0)
        `CHK(hresp, 1'b0)
        end_sim();
    end
endmodule // tb_uls_line_status
